// ===== hw/fpm_pkg.sv
package fpm_pkg;

	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned POWERUP_MS = 2000;
	localparam int unsigned LONG_PRESS_MS = 2000;
	localparam int unsigned IDLE_RETURN_MS = 30000;
	localparam int unsigned CAL_TICK_MS = 1000;
	localparam int unsigned DEBOUNCE_MS = 20;
	localparam int unsigned MS_CYCLES = CLK_HZ / 1000;

	localparam logic [11:0] STEP_HEAT_TEMP = 12'h101;
	localparam logic [11:0] STEP_START_DELAY = 12'h103;
	localparam logic [11:0] STEP_SEAL_TIME = 12'h104;
	localparam logic [11:0] STEP_COOL_VALUE = 12'h105;
	localparam logic [11:0] STEP_HOLD_MODE = 12'h106;
	localparam logic [11:0] STEP_AUTOCAL = 12'h107;
	localparam logic [11:0] STEP_LANGUAGE = 12'h201;
	localparam logic [11:0] STEP_SEAL_MODE = 12'h240;
	localparam logic [11:0] STEP_NONE = 12'h000;

	localparam logic [11:0] ERR_CAL_A = 12'h111;
	localparam logic [11:0] ERR_CAL_B = 12'h114;
	localparam logic [11:0] ERR_CAL_C = 12'h211;

	localparam logic [3:0] CAL_COUNT_START = 4'hE;
	localparam logic [7:0] FW_VERSION = 8'h07;

	localparam logic [9:0] ZERO_OUT_LOW_RANGE = 10'h042;
	localparam logic [9:0] ZERO_OUT_HIGH_RANGE = 10'h028;

	typedef enum logic [1:0] {
		FPM_CAL_OK,
		FPM_CAL_FAIL_A,
		FPM_CAL_FAIL_B,
		FPM_CAL_FAIL_C
	} fpm_cal_result_e;

	typedef enum logic [3:0] {
		FPM_POWERUP,
		FPM_HOME,
		FPM_SETTINGS,
		FPM_CONFIG,
		FPM_ALARM,
		FPM_CAL_SELECT,
		FPM_CAL_RUN
	} fpm_view_e;

	localparam logic [2:0] VIEW_CODE_POWERUP = 3'h0;
	localparam logic [2:0] VIEW_CODE_HOME = 3'h1;
	localparam logic [2:0] VIEW_CODE_MENU = 3'h2;
	localparam logic [2:0] VIEW_CODE_ALARM = 3'h3;
	localparam logic [2:0] VIEW_CODE_CAL_WAIT = 3'h4;

endpackage : fpm_pkg

// ===== hw/fpm_navigator.sv
// Summary of operation
// R1 - Power-up screen with firmware version shows about two seconds, then normal display.
// R2 - Idle without alarm shows home: set temperature, actual number and bar.
// R3 - Fault monitoring always runs; a fault shows as alarm at once; the code holds it back until the power-up screen ends or calibration reports.
// R4 - Short menu press advances to next menu step from home or any menu step; the code ignores it in calibration select (step 107 from alarm).
// R5 - Long press in menus returns home, or to alarm menu if alarm.
// R6 - Long press in home or alarm view jumps to configuration step 201.
// R7 - Thirty seconds without keys in a menu step returns home.
// R8 - No inactivity return during calibration step or alarm menu.
// R9 - Any raised alarm switches the display into the alarm menu.
// R10 - Reset key clears acknowledgeable faults and returns home; others stay.
// R11 - In alarm menu, calibratable fault: short press selects calibration, enter starts it.
// R12 - Long press in alarm menu jumps to configuration step 201.
// R13 - Configuration entered from alarm returns to alarm on long press or timeout.
// R14 - Calibration failing from bad configuration raises alarm code 111, 114 or 211.
// R15 - Successful calibration leaves calibration display and shows the main view.
// R16 - Manual heat key starts heating only in home view and unlocked by step 213.
// R17 - After calibration at 20 C output reads 0.66 V or 0.4 V by range.
// R18 - Steps are three-digit: settings 101..107, configuration 201..240.
// R19 - During calibration show countdown 14 to 0 and force output zero.
// R20 - Press timed from debounced edge; long fires at threshold, short on release.
`timescale 1ns/1ns
`default_nettype none

module fpm_navigator
	import fpm_pkg::*;
#(
	parameter int unsigned POWERUP_CYCLES = POWERUP_MS * MS_CYCLES,
	parameter int unsigned LONG_CYCLES = LONG_PRESS_MS * MS_CYCLES,
	parameter int unsigned IDLE_CYCLES = IDLE_RETURN_MS * MS_CYCLES,
	parameter int unsigned CAL_TICK_CYCLES = CAL_TICK_MS * MS_CYCLES,
	parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * MS_CYCLES
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic menu_key,
	input wire logic enter_key,
	input wire logic reset_key,
	input wire logic manual_heat_key,
	input wire logic fault_active,
	input wire logic fault_ackable,
	input wire logic fault_cal_curable,
	input wire logic [11:0] fault_code,
	input wire logic manual_heat_locked,
	input wire logic high_range,
	input wire logic cal_done,
	input wire logic [1:0] cal_result,
	input wire logic [9:0] actual_out_in,
	output logic [2:0] view_code,
	output logic [11:0] menu_step,
	output logic [7:0] fw_version,
	output logic alarm_shown,
	output logic [11:0] alarm_code,
	output logic [3:0] cal_countdown,
	output logic cal_start,
	output logic manual_heat_start,
	output logic alarm_clear,
	output logic [9:0] actual_out
);

	typedef struct packed {
		fpm_view_e view;
		logic cfg_from_alarm;
		logic [11:0] step;
		logic [31:0] timer;
		logic [31:0] idle;
		logic [31:0] press;
		logic [31:0] deb;
		logic key_raw;
		logic key_db;
		logic long_fired;
		logic enter_q;
		logic reset_q;
		logic heat_q;
		logic cal_alarm;
		logic [11:0] cal_code;
		logic [3:0] countdown;
		logic cal_start;
		logic heat_start;
		logic alarm_clear;
		logic [9:0] aout;
	} fpm_state_s;

	fpm_state_s cur;
	fpm_state_s nxt;

	// Next step in the menu ring, wrapping settings and configuration separately
	function automatic logic [11:0] fpm_next_step(input logic [11:0] s);
		case (s)
			STEP_HEAT_TEMP: fpm_next_step = STEP_START_DELAY;
			STEP_START_DELAY: fpm_next_step = STEP_SEAL_TIME;
			STEP_SEAL_TIME: fpm_next_step = STEP_COOL_VALUE;
			STEP_COOL_VALUE: fpm_next_step = STEP_HOLD_MODE;
			STEP_HOLD_MODE: fpm_next_step = STEP_AUTOCAL;
			STEP_AUTOCAL: fpm_next_step = STEP_HEAT_TEMP;
			STEP_SEAL_MODE: fpm_next_step = STEP_LANGUAGE;
			default:
			begin
				// Decimal carry keeps the step a three-digit number
				if (s[3:0] == 4'h9)
					fpm_next_step = {s[11:8], s[7:4] + 4'h1, 4'h0};
				else
					fpm_next_step = s + 12'h001;
			end
		endcase
	endfunction : fpm_next_step

	function automatic logic [11:0] fpm_cal_code(input logic [1:0] r);
		case (r)
			FPM_CAL_FAIL_A: fpm_cal_code = ERR_CAL_A;
			FPM_CAL_FAIL_B: fpm_cal_code = ERR_CAL_B;
			FPM_CAL_FAIL_C: fpm_cal_code = ERR_CAL_C;
			default: fpm_cal_code = STEP_NONE;
		endcase
	endfunction : fpm_cal_code

	logic alarm_any;
	logic press_edge;
	logic short_ev;
	logic long_ev;
	logic enter_ev;
	logic reset_ev;
	logic heat_ev;
	logic any_key_ev;

	assign alarm_any = fault_active || cur.cal_alarm;
	assign enter_ev = enter_key && !cur.enter_q;
	assign reset_ev = reset_key && !cur.reset_q;
	assign heat_ev = manual_heat_key && !cur.heat_q;

	always_comb
	begin
		nxt = cur;
		short_ev = 1'b0;
		long_ev = 1'b0;
		nxt.cal_start = 1'b0;
		nxt.heat_start = 1'b0;
		nxt.alarm_clear = 1'b0;
		nxt.enter_q = enter_key;
		nxt.reset_q = reset_key;
		nxt.heat_q = manual_heat_key;

		// Debounce the menu key: accept a new level after it holds steady
		if (menu_key != cur.key_raw)
		begin
			nxt.key_raw = menu_key;
			nxt.deb = 32'h0;
		end
		else if (cur.deb >= DEBOUNCE_CYCLES)
			nxt.key_db = cur.key_raw;
		else
			nxt.deb = cur.deb + 32'h1;
		press_edge = nxt.key_db && !cur.key_db;

		// Press timing from the debounced edge
		if (press_edge) //R20
		begin
			nxt.press = 32'h0;
			nxt.long_fired = 1'b0;
		end
		else if (cur.key_db && nxt.key_db && !cur.long_fired)
		begin
			nxt.press = cur.press + 32'h1;
			if (cur.press + 32'h1 >= LONG_CYCLES)
			begin
				long_ev = 1'b1; //R20
				nxt.long_fired = 1'b1;
			end
		end
		if (cur.key_db && !nxt.key_db && !cur.long_fired)
			short_ev = 1'b1; //R20

		// Inactivity timer, held at zero in the alarm menu, calibration select and run, and at settings step 107
		any_key_ev = press_edge || enter_ev || reset_ev || heat_ev;
		if (any_key_ev || cur.view == FPM_CAL_RUN || cur.view == FPM_ALARM ||
			cur.view == FPM_CAL_SELECT ||
			(cur.view == FPM_SETTINGS && cur.step == STEP_AUTOCAL)) //R8
			nxt.idle = 32'h0;
		else if (cur.idle < IDLE_CYCLES)
			nxt.idle = cur.idle + 32'h1;

		case (cur.view)
			FPM_POWERUP:
			begin
				nxt.timer = cur.timer + 32'h1;
				if (cur.timer + 32'h1 >= POWERUP_CYCLES) //R1
				begin
					nxt.view = alarm_any ? FPM_ALARM : FPM_HOME; //R2
					nxt.timer = 32'h0;
				end
			end
			FPM_HOME:
			begin
				if (alarm_any)
					nxt.view = FPM_ALARM; //R3 R9
				else if (long_ev)
				begin
					nxt.view = FPM_CONFIG; //R6
					nxt.step = STEP_LANGUAGE;
					nxt.cfg_from_alarm = 1'b0;
				end
				else if (short_ev)
				begin
					nxt.view = FPM_SETTINGS; //R4
					nxt.step = STEP_HEAT_TEMP;
				end
				else if (heat_ev && !manual_heat_locked)
					nxt.heat_start = 1'b1; //R16
			end
			FPM_SETTINGS, FPM_CONFIG:
			begin
				if (alarm_any && !cur.cfg_from_alarm)
					nxt.view = FPM_ALARM; //R9
				else if (long_ev || cur.idle >= IDLE_CYCLES) //R7
				begin
					if (alarm_any)
						nxt.view = FPM_ALARM; //R5 R13
					else
						nxt.view = FPM_HOME; //R5
					nxt.cfg_from_alarm = 1'b0;
					nxt.idle = 32'h0;
				end
				else if (short_ev)
					nxt.step = fpm_next_step(cur.step); //R4 R18
				else if (enter_ev && cur.step == STEP_AUTOCAL && !alarm_any)
				begin
					nxt.view = FPM_CAL_RUN;
					nxt.cal_start = 1'b1;
					nxt.countdown = CAL_COUNT_START;
					nxt.timer = 32'h0;
				end
			end
			// Alarm menu: acknowledge, configuration jump or calibration shortcut
			FPM_ALARM:
			begin
				if (!alarm_any)
					nxt.view = FPM_HOME;
				else if (reset_ev && (fault_ackable || cur.cal_alarm)) //R10
				begin
					nxt.alarm_clear = 1'b1;
					nxt.cal_alarm = 1'b0;
					nxt.view = FPM_HOME;
				end
				else if (long_ev)
				begin
					nxt.view = FPM_CONFIG; //R12
					nxt.step = STEP_LANGUAGE;
					nxt.cfg_from_alarm = 1'b1; //R13
				end
				else if (short_ev && (fault_cal_curable || cur.cal_alarm))
				begin
					nxt.view = FPM_CAL_SELECT; //R11
					nxt.step = STEP_AUTOCAL;
				end
			end
			FPM_CAL_SELECT:
			begin
				if (enter_ev) //R11
				begin
					nxt.view = FPM_CAL_RUN;
					nxt.cal_start = 1'b1;
					nxt.cal_alarm = 1'b0;
					nxt.countdown = CAL_COUNT_START;
					nxt.timer = 32'h0;
				end
				else if (long_ev)
					nxt.view = FPM_ALARM;
			end
			// Calibration wait: count down each tick to zero, and wait there until the engine reports
			FPM_CAL_RUN:
			begin
				nxt.aout = 10'h000; //R19
				if (cur.countdown != 4'h0)
				begin
					nxt.timer = cur.timer + 32'h1;
					if (cur.timer + 32'h1 >= CAL_TICK_CYCLES)
					begin
						nxt.timer = 32'h0;
						nxt.countdown = cur.countdown - 4'h1; //R19
					end
				end
				if (cal_done)
				begin
					if (cal_result == FPM_CAL_OK)
					begin
						nxt.view = FPM_HOME; //R15
						nxt.aout = high_range ? ZERO_OUT_HIGH_RANGE : ZERO_OUT_LOW_RANGE; //R17
					end
					else
					begin
						nxt.cal_alarm = 1'b1; //R14
						nxt.cal_code = fpm_cal_code(cal_result);
						nxt.view = FPM_ALARM;
					end
				end
			end
			default: nxt.view = FPM_HOME;
		endcase

		// Output follows the feed, except zero from calibration entry to its report, then held one cycle at the report's value
		if (nxt.view == FPM_CAL_RUN)
			nxt.aout = 10'h000; //R19
		else if (cur.view != FPM_CAL_RUN)
			nxt.aout = actual_out_in;

		if (rst)
		begin
			nxt = '0;
			nxt.view = FPM_POWERUP;
			nxt.step = STEP_NONE;
		end
	end

	always_ff @(posedge core_clk)
	begin
		cur <= nxt;
	end

	always_comb
	begin
		case (cur.view)
			FPM_POWERUP: view_code = VIEW_CODE_POWERUP;
			FPM_HOME: view_code = VIEW_CODE_HOME;
			FPM_ALARM: view_code = VIEW_CODE_ALARM;
			FPM_CAL_RUN: view_code = VIEW_CODE_CAL_WAIT;
			default: view_code = VIEW_CODE_MENU;
		endcase
	end

	assign menu_step = (cur.view == FPM_SETTINGS || cur.view == FPM_CONFIG ||
		cur.view == FPM_CAL_SELECT || cur.view == FPM_CAL_RUN) ? cur.step : STEP_NONE;
	assign fw_version = FW_VERSION;
	assign alarm_shown = (cur.view == FPM_ALARM);
	assign alarm_code = cur.cal_alarm ? cur.cal_code : fault_code;
	assign cal_countdown = cur.countdown;
	assign cal_start = cur.cal_start;
	assign manual_heat_start = cur.heat_start;
	assign alarm_clear = cur.alarm_clear;
	assign actual_out = cur.aout;

endmodule : fpm_navigator

`default_nettype wire

// ===== verification/fpm_operator.sv
`timescale 1ns/1ns
`default_nettype none
module fpm_operator (
	output logic [3:0] keys
	,
	input wire logic core_clk
);
	initial keys = 4'h0;
	// Key k held n cycles; idles afterwards so that the release takes effect before return
	task automatic hold(input int k, input int n);
		@(posedge core_clk);
		#1;
		keys[k] = 1'b1;
		repeat (n) @(posedge core_clk);
		#1;
		keys[k] = 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
	endtask : hold
endmodule : fpm_operator
`default_nettype wire

// ===== verification/fpm_navigator_chk.sv
`timescale 1ns/1ns
`default_nettype none
module fpm_navigator_chk
	import fpm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic manual_heat_locked,
	input wire logic high_range,
	input wire logic fault_active,
	input wire logic cal_done,
	input wire logic [1:0] cal_result,
	input wire logic [2:0] view_code,
	input wire logic [11:0] menu_step,
	input wire logic alarm_shown,
	input wire logic [11:0] alarm_code,
	input wire logic [3:0] cal_countdown,
	input wire logic cal_start,
	input wire logic manual_heat_start,
	input wire logic alarm_clear,
	input wire logic [9:0] actual_out
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	AST_POWERUP_HOLD: assert property ($fell(rst) |-> (view_code == VIEW_CODE_POWERUP) [*8])
		else $error("powerup screen left too early");
	AST_HOME_VIEW: assert property (view_code == VIEW_CODE_HOME |-> menu_step == STEP_NONE && !alarm_shown)
		else $error("home view shows a step or alarm");
	AST_MENU_STEP: assert property (view_code == VIEW_CODE_MENU |-> menu_step[11:8] inside {4'h1, 4'h2})
		else $error("menu step outside the 100s and 200s");
	AST_HEAT_GATE: assert property (manual_heat_start |-> $past(view_code) == VIEW_CODE_HOME && !$past(manual_heat_locked))
		else $error("manual heat started outside home or while locked");
	AST_CAL_ENTRY: assert property (cal_start |-> ##[0:1] view_code == VIEW_CODE_CAL_WAIT && cal_countdown == CAL_COUNT_START)
		else $error("calibration start without wait view at 14");
	AST_CAL_ZERO: assert property (view_code == VIEW_CODE_CAL_WAIT && $past(view_code) == VIEW_CODE_CAL_WAIT |-> actual_out == 10'h000 && cal_countdown <= $past(cal_countdown))
		else $error("output not zero or countdown rose during calibration");
	AST_CAL_OK: assert property (cal_done && cal_result == 2'h0 && view_code == VIEW_CODE_CAL_WAIT |-> ##[1:2] view_code == VIEW_CODE_HOME)
		else $error("successful calibration did not leave the wait view");
	AST_ZERO_CODE: assert property (cal_done && cal_result == 2'h0 && view_code == VIEW_CODE_CAL_WAIT |-> ##[1:2] actual_out == (high_range ? ZERO_OUT_HIGH_RANGE : ZERO_OUT_LOW_RANGE))
		else $error("wrong output after calibration");
	AST_CAL_FAIL: assert property (cal_done && cal_result != 2'h0 && view_code == VIEW_CODE_CAL_WAIT |-> ##[1:2] alarm_shown && alarm_code == (cal_result == 2'h1 ? ERR_CAL_A : cal_result == 2'h2 ? ERR_CAL_B : ERR_CAL_C))
		else $error("failed calibration without matching alarm");
	AST_CLEAR_HOME: assert property (alarm_clear |-> ##[0:1] view_code == VIEW_CODE_HOME)
		else $error("cleared alarm did not return home");
	AST_FAULT_ALARM: assert property ($rose(fault_active) && view_code == VIEW_CODE_HOME |-> ##[1:2] view_code == VIEW_CODE_ALARM && alarm_shown)
		else $error("fault not shown as alarm");
	cover property (cal_start);
	cover property (alarm_clear);
	cover property (manual_heat_start);
endmodule : fpm_navigator_chk
bind fpm_navigator fpm_navigator_chk chk_i (.core_clk, .rst, .manual_heat_locked, .high_range,
	.fault_active, .cal_done, .cal_result, .view_code, .menu_step, .alarm_shown, .alarm_code,
	.cal_countdown, .cal_start, .manual_heat_start, .alarm_clear, .actual_out);
`default_nettype wire

// ===== verification/fpm_navigator_tb.sv
`timescale 1ns/1ns
`default_nettype none
module fpm_navigator_tb import fpm_pkg::*;;
	localparam logic [11:0] FAULT = 12'h305;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic fault_active = 1'b0;
	logic fault_cal_curable = 1'b0;
	logic manual_heat_locked = 1'b0;
	logic high_range = 1'b0;
	logic cal_done = 1'b0;
	logic [1:0] cal_result = 2'h0;
	logic fault_ackable = 1'b0;
	logic [11:0] fault_code = FAULT;
	logic [9:0] actual_in = 10'h155;
	logic [3:0] keys;
	logic [2:0] view_code;
	logic [11:0] menu_step;
	logic [7:0] fw_version;
	logic alarm_shown;
	logic [11:0] alarm_code;
	logic [3:0] cal_countdown;
	logic cal_start;
	logic manual_heat_start;
	logic alarm_clear;
	logic [9:0] actual_out;
	int fails = 0;
	int n_tests = 0;
	int n_cal = 0;
	int n_heat = 0;
	int n_clr = 0;
	int cyc = 0;
	fpm_operator op (.core_clk, .keys);
	fpm_navigator #(.POWERUP_CYCLES(20), .LONG_CYCLES(50), .IDLE_CYCLES(200),
		.CAL_TICK_CYCLES(10), .DEBOUNCE_CYCLES(2)) dut (.core_clk, .rst, .menu_key(keys[0]),
		.enter_key(keys[1]), .reset_key(keys[2]), .manual_heat_key(keys[3]), .fault_active,
		.fault_ackable, .fault_cal_curable, .fault_code, .manual_heat_locked,
		.high_range, .cal_done, .cal_result, .actual_out_in(actual_in), .view_code, .menu_step,
		.fw_version, .alarm_shown, .alarm_code, .cal_countdown, .cal_start, .manual_heat_start,
		.alarm_clear, .actual_out);
	initial forever #10 core_clk = ~core_clk;
	// One-cycle pulses are tallied here so that scenarios can judge them afterwards
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		n_cal <= n_cal + int'(cal_start);
		n_heat <= n_heat + int'(manual_heat_start);
		n_clr <= n_clr + int'(alarm_clear);
		if (cyc == 20000)
		begin
			fails++;
			final_report();
		end
	end
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic w(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : w
	task automatic done_pulse(input logic [1:0] r);
		cal_result = r;
		cal_done = 1'b1;
		w(1);
		cal_done = 1'b0;
		w(3);
	endtask : done_pulse
	task automatic to_cal;
		repeat (6) op.hold(0, 10);
		chk(menu_step, STEP_AUTOCAL);
		w(250);
		chk(menu_step, STEP_AUTOCAL);
		op.hold(1, 3);
		chk(view_code, VIEW_CODE_CAL_WAIT);
	endtask : to_cal
	task automatic t_powerup;
		w(15);
		chk(view_code, VIEW_CODE_POWERUP);
		chk(fw_version, FW_VERSION);
		w(10);
		chk(view_code, VIEW_CODE_HOME);
		$display("powerup done");
	endtask : t_powerup
	task automatic t_menu;
		logic [11:0] s [6] = '{STEP_HEAT_TEMP, STEP_START_DELAY, STEP_SEAL_TIME,
			STEP_COOL_VALUE, STEP_HOLD_MODE, STEP_AUTOCAL};
		for (int i = 0; i < 7; i++)
		begin
			op.hold(0, 10);
			chk(menu_step, s[i % 6]);
		end
		op.hold(0, 70);
		chk(view_code, VIEW_CODE_HOME);
		$display("menu done");
	endtask : t_menu
	task automatic t_idle;
		op.hold(0, 10);
		w(150);
		chk(view_code, VIEW_CODE_MENU);
		w(70);
		chk(view_code, VIEW_CODE_HOME);
		$display("idle done");
	endtask : t_idle
	task automatic t_config;
		op.hold(0, 70);
		chk(menu_step, STEP_LANGUAGE);
		op.hold(0, 10);
		chk(menu_step, 12'h202);
		repeat (8) op.hold(0, 10);
		chk(menu_step, 12'h210);
		op.hold(0, 70);
		chk(view_code, VIEW_CODE_HOME);
		$display("config done");
	endtask : t_config
	task automatic t_manual;
		int b;
		b = n_heat;
		op.hold(3, 3);
		chk(n_heat, b + 1);
		manual_heat_locked = 1'b1;
		op.hold(3, 3);
		manual_heat_locked = 1'b0;
		op.hold(0, 10);
		op.hold(3, 3);
		chk(n_heat, b + 1);
		op.hold(0, 70);
		$display("manual done");
	endtask : t_manual
	task automatic t_cal(input logic hr);
		int b;
		b = n_cal;
		high_range = hr;
		to_cal();
		chk(n_cal, b + 1);
		chk(actual_out, 10'h000);
		w(300);
		chk(view_code, VIEW_CODE_CAL_WAIT);
		chk(cal_countdown, 4'h0);
		cal_result = 2'h0;
		cal_done = 1'b1;
		w(1);
		cal_done = 1'b0;
		chk(actual_out, hr ? ZERO_OUT_HIGH_RANGE : ZERO_OUT_LOW_RANGE);
		w(3);
		chk(actual_out, actual_in);
		chk(view_code, VIEW_CODE_HOME);
		$display("cal done");
	endtask : t_cal
	task automatic t_calfail;
		logic [11:0] codes [3] = '{ERR_CAL_A, ERR_CAL_B, ERR_CAL_C};
		int b;
		for (int i = 0; i < 3; i++)
		begin
			b = n_clr;
			to_cal();
			done_pulse(2'(i + 1));
			chk(alarm_code, codes[i]);
			op.hold(2, 3);
			chk(n_clr, b + 1);
			chk(view_code, VIEW_CODE_HOME);
		end
		$display("calfail done");
	endtask : t_calfail
	task automatic t_alarm;
		int b;
		fault_cal_curable = 1'b1;
		fault_active = 1'b1;
		w(3);
		chk(view_code, VIEW_CODE_ALARM);
		chk(alarm_code, FAULT);
		b = n_clr;
		op.hold(2, 3);
		chk(n_clr, b);
		w(250);
		chk(view_code, VIEW_CODE_ALARM);
		op.hold(0, 70);
		chk(menu_step, STEP_LANGUAGE);
		w(250);
		chk(view_code, VIEW_CODE_ALARM);
		op.hold(0, 70);
		op.hold(0, 70);
		chk(view_code, VIEW_CODE_ALARM);
		op.hold(0, 10);
		chk(menu_step, STEP_AUTOCAL);
		op.hold(1, 3);
		fault_active = 1'b0;
		done_pulse(2'h0);
		chk(view_code, VIEW_CODE_HOME);
		fault_code = 12'h302;
		fault_ackable = 1'b1;
		fault_active = 1'b1;
		w(3);
		chk(alarm_code, 12'h302);
		b = n_clr;
		op.hold(2, 3);
		chk(n_clr, b + 1);
		fault_active = 1'b0;
		fault_ackable = 1'b0;
		w(2);
		chk(view_code, VIEW_CODE_HOME);
		$display("alarm done");
	endtask : t_alarm
	initial
	begin
		repeat (20) @(posedge core_clk);
		#1;
		rst = 1'b0;
		t_powerup();
		t_menu();
		t_idle();
		t_config();
		t_manual();
		t_cal(1'b0);
		t_cal(1'b1);
		t_calfail();
		t_alarm();
		final_report();
	end
endmodule : fpm_navigator_tb
`default_nettype wire
